/* hdl/timer16_byte_access_counter.sv */
// Byte-wide access path and counter core of the 16-bit timer
`timescale 1ns/10ps
`include "timer16_params.svh"

module timer16_byte_access_counter
  import timer16_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire io_req_s io_req,
  output logic [7:0] io_rdata,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  input wire logic ext_clock_pin,
  output logic timer_tick,
  output logic count_top,
  output logic count_bottom,
  output logic overflow_flag,
  output logic [15:0] count_value
);
  timer_state_s s_r;
  timer_state_s s_nxt;
  logic [3:0] waveform_mode_select;
  logic [2:0] clock_source_select;
  logic [15:0] top_value;
  logic dual_slope;
  logic cap_top;
  logic ovf_at_max;
  logic cap_edge;
  logic retrigger_request;
  logic at_top;
  logic tov_set;
  logic tov_clr;

  assign waveform_mode_select = {s_r.ctrl_b[`WGM_HI_MSB:`WGM_HI_LSB],
                                 s_r.ctrl_a[`WGM_LO_MSB:`WGM_LO_LSB]};
  assign clock_source_select = s_r.ctrl_b[`CS_MSB:`CS_LSB];
  assign cap_edge = (capture_input_a & ~s_r.cap_a_prev) |
                    (capture_input_b & ~s_r.cap_b_prev);
  assign retrigger_request = cap_edge | s_r.rtg_pend;

  // Timer tick from clock select
  always_comb begin
    case (clock_source_select)
      `CS_DIV1: timer_tick = 1'b1;
      `CS_DIV8: timer_tick = &s_r.presc[`P8_MSB:0];
      `CS_DIV64: timer_tick = &s_r.presc[`P64_MSB:0];
      `CS_DIV256: timer_tick = &s_r.presc[`P256_MSB:0];
      `CS_DIV1024: timer_tick = &s_r.presc[`P1024_MSB:0];
      `CS_EXT_FALL: timer_tick = s_r.ext_prev & ~ext_clock_pin;
      `CS_EXT_RISE: timer_tick = ~s_r.ext_prev & ext_clock_pin;
      default: timer_tick = 1'b0;
    endcase
  end

  // Top value and slope by mode
  always_comb begin
    dual_slope = 1'b0;
    cap_top = 1'b0;
    ovf_at_max = 1'b0;
    case (waveform_mode_select)
      `WGM_PC8: begin
        top_value = `TOP_8BIT;
        dual_slope = 1'b1;
      end
      `WGM_PC9: begin
        top_value = `TOP_9BIT;
        dual_slope = 1'b1;
      end
      `WGM_PC10: begin
        top_value = `TOP_10BIT;
        dual_slope = 1'b1;
      end
      `WGM_FAST8: top_value = `TOP_8BIT;
      `WGM_FAST9: top_value = `TOP_9BIT;
      `WGM_FAST10: top_value = `TOP_10BIT;
      `WGM_CTC_CMP: begin
        top_value = s_r.cmp_a;
        ovf_at_max = 1'b1;
      end
      `WGM_PFC_CMP, `WGM_PC_CMP: begin
        top_value = s_r.cmp_a;
        dual_slope = 1'b1;
      end
      `WGM_FAST_CMP: top_value = s_r.cmp_a;
      `WGM_PFC_CAP, `WGM_PC_CAP: begin
        top_value = s_r.cap;
        dual_slope = 1'b1;
        cap_top = 1'b1;
      end
      `WGM_CTC_CAP: begin
        top_value = s_r.cap;
        cap_top = 1'b1;
        ovf_at_max = 1'b1;
      end
      `WGM_FAST_CAP: begin
        top_value = s_r.cap;
        cap_top = 1'b1;
      end
      default: begin
        top_value = `COUNT_MAX;
        ovf_at_max = 1'b1;
      end
    endcase
  end

  assign at_top = (s_r.count == top_value) | retrigger_request;
  assign tov_clr = io_req.wr & (io_req.addr == `ADDR_FLAGS) & io_req.wdata[`TOV_BIT];

  // Next state
  always_comb begin
    s_nxt = s_r;
    tov_set = 1'b0;
    s_nxt.presc = s_r.presc + `ONE10;
    s_nxt.ext_prev = ext_clock_pin;
    s_nxt.cap_a_prev = capture_input_a;
    s_nxt.cap_b_prev = capture_input_b;
    if (cap_edge && !cap_top) begin
      s_nxt.cap = s_r.count;
    end
    if (timer_tick) begin
      s_nxt.rtg_pend = 1'b0;
    end else if (cap_edge) begin
      s_nxt.rtg_pend = 1'b1;
    end
    if (timer_tick) begin
      if (dual_slope) begin
        if (s_r.dir == DIR_UP) begin
          if (at_top) begin
            s_nxt.dir = DIR_DOWN;
            s_nxt.count = s_r.count - `ONE16;
          end else begin
            s_nxt.count = s_r.count + `ONE16;
          end
        end else if (s_r.count == `COUNT_ZERO) begin
          s_nxt.dir = DIR_UP;
          s_nxt.count = s_r.count + `ONE16;
          tov_set = 1'b1;
        end else begin
          s_nxt.count = s_r.count - `ONE16;
        end
      end else begin
        s_nxt.dir = DIR_UP;
        if (at_top) begin
          s_nxt.count = `COUNT_ZERO;
        end else begin
          s_nxt.count = s_r.count + `ONE16;
        end
        tov_set = ovf_at_max ? (s_r.count == `COUNT_MAX) : at_top;
      end
    end
    s_nxt.tov = (s_r.tov & ~tov_clr) | tov_set;
    // Reads
    if (io_req.rd) begin
      case (io_req.addr)
        `ADDR_CTRL_A: s_nxt.rdata = s_r.ctrl_a;
        `ADDR_CTRL_B: s_nxt.rdata = s_r.ctrl_b;
        `ADDR_CNT_LO: begin
          s_nxt.rdata = s_r.count[7:0];
          s_nxt.temp = s_r.count[15:8];
        end
        `ADDR_CAP_LO: begin
          s_nxt.rdata = s_r.cap[7:0];
          s_nxt.temp = s_r.cap[15:8];
        end
        `ADDR_CNT_HI, `ADDR_CAP_HI: s_nxt.rdata = s_r.temp;
        `ADDR_CMPA_LO: s_nxt.rdata = s_r.cmp_a[7:0];
        `ADDR_CMPA_HI: s_nxt.rdata = s_r.cmp_a[15:8];
        `ADDR_CMPB_LO: s_nxt.rdata = s_r.cmp_b[7:0];
        `ADDR_CMPB_HI: s_nxt.rdata = s_r.cmp_b[15:8];
        `ADDR_FLAGS: s_nxt.rdata = {7'h00, s_r.tov};
        default: s_nxt.rdata = `BYTE_ZERO;
      endcase
    end
    // Writes, after counting so they win
    if (io_req.wr) begin
      case (io_req.addr)
        `ADDR_CTRL_A: s_nxt.ctrl_a = io_req.wdata;
        `ADDR_CTRL_B: s_nxt.ctrl_b = io_req.wdata;
        `ADDR_CNT_LO: s_nxt.count = {s_r.temp, io_req.wdata};
        `ADDR_CAP_LO: begin
          if (cap_top) begin
            s_nxt.cap = {s_r.temp, io_req.wdata};
          end
        end
        `ADDR_CMPA_LO: s_nxt.cmp_a = {s_r.temp, io_req.wdata};
        `ADDR_CMPB_LO: s_nxt.cmp_b = {s_r.temp, io_req.wdata};
        `ADDR_CNT_HI, `ADDR_CAP_HI, `ADDR_CMPA_HI, `ADDR_CMPB_HI: begin
          s_nxt.temp = io_req.wdata;
        end
        default: s_nxt.tov = s_nxt.tov;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign io_rdata = s_r.rdata;
  assign count_value = s_r.count;
  assign count_top = (s_r.count == top_value);
  assign count_bottom = (s_r.count == `COUNT_ZERO);
  assign overflow_flag = s_r.tov;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_low_cnt_wr;
    io_req.wr && io_req.addr == `ADDR_CNT_LO;
  endsequence
  sequence s_low_cnt_rd;
    io_req.rd && !io_req.wr && io_req.addr == `ADDR_CNT_LO;
  endsequence

  property p_low_write_loads;
    s_low_cnt_wr |=> count_value == {$past(s_r.temp), $past(io_req.wdata)};
  endproperty
  a_low_write_loads: assert property (p_low_write_loads) else $error("low write bad");

  property p_write_wins;
    s_low_cnt_wr ##0 timer_tick |=> count_value == {$past(s_r.temp), $past(io_req.wdata)};
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to count");

  property p_low_read_copies;
    s_low_cnt_rd |=> s_r.temp == $past(count_value[15:8]) && io_rdata == $past(count_value[7:0]);
  endproperty
  a_low_read_copies: assert property (p_low_read_copies) else $error("low read bad");

  property p_cmp_read_direct;
    io_req.rd && !io_req.wr && io_req.addr == `ADDR_CMPA_HI
      |=> io_rdata == $past(s_r.cmp_a[15:8]) && $stable(s_r.temp);
  endproperty
  a_cmp_read_direct: assert property (p_cmp_read_direct) else $error("cmp read bad");

  property p_high_read_temp;
    io_req.rd && !io_req.wr && io_req.addr == `ADDR_CNT_HI |=> io_rdata == $past(s_r.temp);
  endproperty
  a_high_read_temp: assert property (p_high_read_temp) else $error("high read bad");

  property p_high_write_only_temp;
    io_req.wr && io_req.addr == `ADDR_CMPA_HI
      |=> s_r.temp == $past(io_req.wdata) && $stable(s_r.cmp_a);
  endproperty
  a_high_write_only_temp: assert property (p_high_write_only_temp) else $error("hi wr bad");

  property p_stopped;
    clock_source_select == `CS_STOP && !io_req.wr [*2] |=> $stable(count_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_normal_inc;
    timer_tick && waveform_mode_select == `WGM_NORMAL && !io_req.wr && !retrigger_request
      && count_value != `COUNT_MAX |=> count_value == $past(count_value) + `ONE16;
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("increment bad");

  property p_ovf_set;
    timer_tick && waveform_mode_select == `WGM_NORMAL && count_value == `COUNT_MAX
      |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_retrigger;
    cap_edge && timer_tick && !dual_slope && !io_req.wr |=> count_value == `COUNT_ZERO;
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("retrigger ignored");

  property p_top_turn;
    timer_tick && dual_slope && s_r.dir == DIR_UP && count_top && !io_req.wr
      |=> s_r.dir == DIR_DOWN && count_value == $past(count_value) - `ONE16;
  endproperty
  a_top_turn: assert property (p_top_turn) else $error("no turn at top");

  property p_bottom_flag;
    timer_tick && dual_slope && s_r.dir == DIR_DOWN && count_bottom
      |=> overflow_flag && s_r.dir == DIR_UP;
  endproperty
  a_bottom_flag: assert property (p_bottom_flag) else $error("bottom flag bad");
endmodule

/* shared/timer16_params.svh */
// Register indices, field positions, mode codes and fixed values of the 16-bit timer
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define ADDR_CTRL_A 4'h0
`define ADDR_CTRL_B 4'h1
`define ADDR_CNT_LO 4'h2
`define ADDR_CNT_HI 4'h3
`define ADDR_CAP_LO 4'h4
`define ADDR_CAP_HI 4'h5
`define ADDR_CMPA_LO 4'h6
`define ADDR_CMPA_HI 4'h7
`define ADDR_CMPB_LO 4'h8
`define ADDR_CMPB_HI 4'h9
`define ADDR_FLAGS 4'ha
`define WGM_LO_MSB 1
`define WGM_LO_LSB 0
`define WGM_HI_MSB 4
`define WGM_HI_LSB 3
`define CS_MSB 2
`define CS_LSB 0
`define TOV_BIT 0
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define P8_MSB 2
`define P64_MSB 5
`define P256_MSB 7
`define P1024_MSB 9
`define WGM_NORMAL 4'h0
`define WGM_PC8 4'h1
`define WGM_PC9 4'h2
`define WGM_PC10 4'h3
`define WGM_CTC_CMP 4'h4
`define WGM_FAST8 4'h5
`define WGM_FAST9 4'h6
`define WGM_FAST10 4'h7
`define WGM_PFC_CAP 4'h8
`define WGM_PFC_CMP 4'h9
`define WGM_PC_CAP 4'ha
`define WGM_PC_CMP 4'hb
`define WGM_CTC_CAP 4'hc
`define WGM_FAST_CAP 4'he
`define WGM_FAST_CMP 4'hf
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define COUNT_MAX 16'hffff
`define COUNT_ZERO 16'h0000
`define ONE16 16'h0001
`define ONE10 10'h001
`define BYTE_ZERO 8'h00
`endif

/* shared/timer16_pkg.sv */
// Types shared by the 16-bit timer
package timer16_pkg;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_s;
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] temp;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic tov;
    dir_e dir;
    logic [9:0] presc;
    logic [7:0] rdata;
    logic cap_a_prev;
    logic cap_b_prev;
    logic ext_prev;
    logic rtg_pend;
  } timer_state_s;
endpackage

/* tb/cpu_bus_model.sv */
// Processor model on the byte-wide timer register bus
`timescale 1ns/10ps
module cpu_bus_model
  import timer16_pkg::*;
(
  input wire logic clock,
  output io_req_s io_req,
  input wire logic [7:0] io_rdata
);
  initial io_req = '{addr: 4'h0, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

  // One byte access, strobe held for a single edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clock);
    io_req <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clock);
    q = io_rdata;
    io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  // Two-byte write, nothing interleaved
  task automatic w16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, lo + 4'h1, v[15:8], q);
    acc(1'b1, lo, v[7:0], q);
  endtask

  // Two-byte read, nothing interleaved
  task automatic r16(input logic [3:0] lo, output logic [15:0] v);
    acc(1'b0, lo, 8'h00, v[7:0]);
    acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
  endtask
endmodule

/* tb/timer16_byte_access_counter_tb.sv */
// Self-checking bench of the byte access path and counter core
`timescale 1ns/10ps
`include "timer16_params.svh"
module timer16_byte_access_counter_tb
  import timer16_pkg::*;
;
  logic clock, reset_n, cap_a, cap_b, ext_clk;
  io_req_s io_req;
  logic [7:0] io_rdata, q;
  logic timer_tick, count_top, count_bottom, overflow_flag;
  logic [15:0] count_value, lf, v;
  logic [3:0] m;
  int error_cnt, n_tests, cyc;

  timer16_byte_access_counter u_dut (.clock(clock), .reset_n(reset_n),
    .io_req(io_req), .io_rdata(io_rdata), .capture_input_a(cap_a),
    .capture_input_b(cap_b), .ext_clock_pin(ext_clk), .timer_tick(timer_tick),
    .count_top(count_top), .count_bottom(count_bottom),
    .overflow_flag(overflow_flag), .count_value(count_value));

  cpu_bus_model u_cpu (.clock(clock), .io_req(io_req), .io_rdata(io_rdata));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Top of a mode, compare A preset to 0x1234
  function automatic logic [15:0] top_of(input logic [3:0] md);
    case (md[1:0])
      2'h1: return `TOP_8BIT;
      2'h2: return `TOP_9BIT;
      2'h3: return `TOP_10BIT;
      default: return 16'h1234;
    endcase
  endfunction

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    reset_n = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    ext_clk = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    lf = 16'h0024;
    repeat (4) @(posedge clock);
    chk16(count_value, `COUNT_ZERO);
    chk1(count_bottom, 1'b1);
    chk1(overflow_flag, 1'b0);
    @(negedge clock);
    reset_n = 1'b1;
    repeat (5) @(negedge clock);
    chk1(timer_tick, 1'b0);
    chk16(count_value, `COUNT_ZERO);
    u_cpu.acc(1'b1, `ADDR_CNT_HI, 8'h01, q);
    chk16(count_value, `COUNT_ZERO);
    u_cpu.acc(1'b1, `ADDR_CNT_LO, 8'hff, q);
    chk16(count_value, 16'h01ff);
    u_cpu.r16(`ADDR_CNT_LO, v);
    chk16(v, 16'h01ff);
    // Holding byte shared and reused
    u_cpu.acc(1'b1, `ADDR_CMPA_HI, 8'ha5, q);
    u_cpu.acc(1'b1, `ADDR_CMPA_LO, 8'h11, q);
    u_cpu.acc(1'b1, `ADDR_CNT_LO, 8'h22, q);
    chk16(count_value, 16'ha522);
    u_cpu.w16(`ADDR_CNT_LO, 16'h3c00);
    u_cpu.r16(`ADDR_CMPA_LO, v);
    chk16(v, 16'ha511);
    u_cpu.acc(1'b0, `ADDR_CNT_HI, 8'h00, q);
    chk16({8'h00, q}, 16'h003c);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      u_cpu.w16(`ADDR_CNT_LO, lf);
      chk16(count_value, lf);
      u_cpu.r16(`ADDR_CNT_LO, v);
      chk16(v, lf);
    end
    // Top per mode, fixed or from compare A
    u_cpu.w16(`ADDR_CMPA_LO, 16'h1234);
    for (int i = 1; i < 8; i++) begin
      m = 4'(i);
      u_cpu.acc(1'b1, `ADDR_CTRL_A, {6'h00, m[1:0]}, q);
      u_cpu.acc(1'b1, `ADDR_CTRL_B, {4'h0, m[2], 3'h0}, q);
      u_cpu.w16(`ADDR_CNT_LO, top_of(m));
      chk1(count_top, 1'b1);
      u_cpu.w16(`ADDR_CNT_LO, top_of(m) - `ONE16);
      chk1(count_top, 1'b0);
    end
    u_cpu.acc(1'b1, `ADDR_CTRL_A, 8'h00, q);
    u_cpu.w16(`ADDR_CNT_LO, `COUNT_MAX);
    u_cpu.acc(1'b1, `ADDR_CTRL_B, {5'h00, `CS_DIV1}, q);
    for (int i = 0; i < 8 && overflow_flag !== 1'b1; i++) @(negedge clock);
    chk1(overflow_flag, 1'b1);
    chk16(count_value, `COUNT_ZERO);
    u_cpu.w16(`ADDR_CNT_LO, 16'h4321);
    chk16(count_value, 16'h4321);
    @(negedge clock);
    chk16(count_value, 16'h4322);
    for (int k = 0; k < 2; k++) begin
      u_cpu.w16(`ADDR_CNT_LO, 16'h0010);
      if (k == 0) cap_a = 1'b1;
      else cap_b = 1'b1;
      for (int i = 0; i < 8 && count_value !== `COUNT_ZERO; i++) @(negedge clock);
      chk16(count_value, `COUNT_ZERO);
      cap_a = 1'b0;
      cap_b = 1'b0;
    end
    u_cpu.r16(`ADDR_CAP_LO, v);
    chk16(v, 16'h0010);
    u_cpu.acc(1'b1, `ADDR_CTRL_B, 8'h00, q);
    u_cpu.acc(1'b1, `ADDR_FLAGS, 8'h01, q);
    chk1(overflow_flag, 1'b0);
    // Dual slope turns down at top and up at bottom
    u_cpu.acc(1'b1, `ADDR_CTRL_A, 8'h01, q);
    u_cpu.w16(`ADDR_CNT_LO, `TOP_8BIT - `ONE16);
    u_cpu.acc(1'b1, `ADDR_CTRL_B, {5'h00, `CS_DIV1}, q);
    @(negedge clock);
    chk16(count_value, `TOP_8BIT);
    chk1(count_top, 1'b1);
    @(negedge clock);
    chk16(count_value, `TOP_8BIT - `ONE16);
    u_cpu.w16(`ADDR_CNT_LO, 16'h0002);
    chk16(count_value, 16'h0002);
    repeat (2) @(negedge clock);
    chk1(count_bottom, 1'b1);
    @(negedge clock);
    chk16(count_value, `ONE16);
    chk1(overflow_flag, 1'b1);
    u_cpu.acc(1'b0, `ADDR_FLAGS, 8'h00, q);
    chk16({8'h00, q}, 16'h0001);
    // Prescaled and external ticks in normal mode
    u_cpu.acc(1'b1, `ADDR_CTRL_B, 8'h00, q);
    u_cpu.acc(1'b1, `ADDR_CTRL_A, 8'h00, q);
    u_cpu.w16(`ADDR_CNT_LO, 16'h0100);
    u_cpu.acc(1'b1, `ADDR_CTRL_B, {5'h00, `CS_DIV8}, q);
    repeat (64) @(negedge clock);
    chk16(count_value, 16'h0108);
    u_cpu.acc(1'b1, `ADDR_CTRL_B, {5'h00, `CS_EXT_RISE}, q);
    u_cpu.w16(`ADDR_CNT_LO, 16'h0200);
    repeat (3) begin
      @(negedge clock);
      ext_clk = 1'b1;
      @(negedge clock);
      ext_clk = 1'b0;
    end
    chk16(count_value, 16'h0203);
    final_report();
  end
endmodule
